/* File: core/power_down_pkg.sv */
// constants and types of the power-down and output buffer register bank
package power_down_pkg;

    // -----------------------------------------------------------------
    // serial control frame
    // -----------------------------------------------------------------
    localparam int ADDR_BITS = 15;
    localparam int HEADER_BITS = 16;
    localparam int FRAME_BITS = 24;
    localparam int COUNT_BITS = 5;
    localparam logic [COUNT_BITS-1:0] HEADER_LAST = 5'h0f;
    localparam logic [COUNT_BITS-1:0] FRAME_LAST = 5'h17;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [ADDR_BITS-1:0] ADDR_POWER_CONTROL = 15'h0008;
    localparam logic [ADDR_BITS-1:0] ADDR_OUTPUT_BUFFER_DISABLE_LOW = 15'h000a;
    localparam logic [ADDR_BITS-1:0] ADDR_OUTPUT_BUFFER_DISABLE_MID = 15'h000b;
    localparam logic [ADDR_BITS-1:0] ADDR_OUTPUT_BUFFER_DISABLE_HIGH = 15'h000c;
    localparam logic [ADDR_BITS-1:0] ADDR_GLOBAL_POWERDOWN_MASK = 15'h000d;

    // -----------------------------------------------------------------
    // field positions, writable bits, reset value
    // -----------------------------------------------------------------
    localparam int POS_CLOCK_BUFFER_OFF = 5;
    localparam int POS_REFERENCE_AMP_OFF = 4;
    localparam int POS_CHANNEL_A_OFF = 2;
    localparam int POS_CHANNEL_B_OFF = 1;
    localparam int POS_GLOBAL_SLEEP = 0;
    localparam int POS_KEEP_CLOCK_BUFFER = 3;
    localparam int POS_KEEP_REFERENCE_AMP = 2;
    localparam int POS_BANDGAP_SLEEP_SELECT = 1;
    localparam logic [7:0] POWER_CONTROL_WRITABLE = 8'h37;
    localparam logic [7:0] GLOBAL_MASK_WRITABLE = 8'h0e;
    localparam logic [7:0] REGISTER_RESET = 8'h00;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        SEL_NONE, SEL_POWER, SEL_OB_LOW, SEL_OB_MID, SEL_OB_HIGH, SEL_MASK
    } reg_select_t;

    typedef enum {SER_IDLE, SER_HEADER, SER_DATA, SER_DONE} serial_state_t;

    typedef struct packed {
        logic clock_buffer_off;
        logic reference_amp_off;
        logic channel_a_off;
        logic channel_b_off;
        logic bandgap_off;
    } power_state_t;

    typedef struct packed {
        logic [6:0] chan_a;
        logic [6:0] chan_b;
    } pin_disable_t;

endpackage

/* File: core/power_down_output_buffer_ctrl.sv */
// power-down and output buffer disable registers behind the serial control port
//
// What this block does
// - control bit 5 powers down clock buffer
// - control bit 4 powers down reference amplifier
// - control bit 2 powers down channel A
// - control bit 1 powers down channel B
// - control bit 0 enters masked global sleep
// - three bytes form 24-bit buffer disable field
// - field leaves data and serial clocks alone
// - disable bits map to fixed channel pins
// - mask bits 3,2,1: clock, amp, bandgap
// - clock and amp masks exempt blocks from global sleep
// - bandgap mask set sleeps bandgap globally
`timescale 1ns/1ps

module power_down_output_buffer_ctrl
    import power_down_pkg::*;
(
    input wire logic REF_CLK, // 10 MHz system clock
    input wire logic RESET, // synchronous, active high
    input wire logic SEN_N, // serial enable, low during a frame
    input wire logic SCLK, // serial clock, sampled on REF_CLK
    input wire logic SDATA, // serial data in
    output logic SDOUT, // serial read data out
    output logic SDOUT_OE, // high while SDOUT is driven
    output power_state_t POWER_DOWN, // analog block power-down controls
    output pin_disable_t PIN_DISABLE, // per-pin output buffer power-down
    output logic [23:0] OUTPUT_BUFFER_DISABLE // raw disable field
);

    // -----------------------------------------------------------------
    // address decode
    // -----------------------------------------------------------------
    function automatic reg_select_t decode(input logic [ADDR_BITS-1:0] addr);
        reg_select_t sel;
        sel = SEL_NONE;
        unique case (addr)
            ADDR_POWER_CONTROL: sel = SEL_POWER;
            ADDR_OUTPUT_BUFFER_DISABLE_LOW: sel = SEL_OB_LOW;
            ADDR_OUTPUT_BUFFER_DISABLE_MID: sel = SEL_OB_MID;
            ADDR_OUTPUT_BUFFER_DISABLE_HIGH: sel = SEL_OB_HIGH;
            ADDR_GLOBAL_POWERDOWN_MASK: sel = SEL_MASK;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    logic [7:0] power_control;
    logic [7:0] output_buffer_disable_low;
    logic [7:0] output_buffer_disable_mid;
    logic [7:0] output_buffer_disable_high;
    logic [7:0] global_powerdown_mask;

    // -----------------------------------------------------------------
    // serial frame receiver
    // -----------------------------------------------------------------
    serial_state_t state;
    logic sclk_q;
    logic [COUNT_BITS-1:0] bit_count;
    logic [FRAME_BITS-2:0] shift_in;
    logic [7:0] read_shift;
    logic sclk_rise;
    logic sclk_fall;
    logic shifting;
    logic [FRAME_BITS-1:0] frame;
    logic write_commit;
    logic [ADDR_BITS-1:0] header_addr;

    assign sclk_rise = SCLK & ~sclk_q;
    assign sclk_fall = ~SCLK & sclk_q;
    assign shifting = ~SEN_N & sclk_rise & (state != SER_DONE);
    assign frame = {shift_in, SDATA};
    assign header_addr = {shift_in[ADDR_BITS-2:0], SDATA};
    assign write_commit = shifting & (state == SER_DATA) & (bit_count == FRAME_LAST)
        & ~frame[FRAME_BITS-1];

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= SCLK;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state <= SER_IDLE;
            bit_count <= '0;
            shift_in <= '0;
        end else if (SEN_N) begin
            state <= SER_IDLE;
            bit_count <= '0;
        end else begin
            unique case (state)
                SER_IDLE, SER_HEADER: begin
                    state <= SER_HEADER;
                    if (shifting) begin
                        shift_in <= frame[FRAME_BITS-2:0];
                        bit_count <= bit_count + 5'h01;
                        if (bit_count == HEADER_LAST) begin
                            state <= SER_DATA;
                        end
                    end
                end
                SER_DATA: begin
                    if (shifting) begin
                        shift_in <= frame[FRAME_BITS-2:0];
                        bit_count <= bit_count + 5'h01;
                        if (bit_count == FRAME_LAST) begin
                            state <= SER_DONE;
                        end
                    end
                end
                SER_DONE: begin
                    state <= SER_DONE;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // read-back path
    // -----------------------------------------------------------------
    function automatic logic [7:0] read_byte(input reg_select_t sel);
        logic [7:0] value;
        value = 8'h00;
        unique case (sel)
            SEL_POWER: value = power_control;
            SEL_OB_LOW: value = output_buffer_disable_low;
            SEL_OB_MID: value = output_buffer_disable_mid;
            SEL_OB_HIGH: value = output_buffer_disable_high;
            SEL_MASK: value = global_powerdown_mask;
            SEL_NONE: value = 8'h00;
        endcase
        return value;
    endfunction

    // read bit leads header; data leaves msb first on falling edges
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            read_shift <= 8'h00;
            SDOUT <= 1'b0;
            SDOUT_OE <= 1'b0;
        end else if (SEN_N) begin
            SDOUT_OE <= 1'b0;
            SDOUT <= 1'b0;
        end else if (shifting && state == SER_HEADER && bit_count == HEADER_LAST) begin
            read_shift <= read_byte(decode(header_addr));
            SDOUT_OE <= shift_in[ADDR_BITS-1];
        end else if (sclk_fall && state == SER_DATA) begin
            SDOUT <= read_shift[7];
            read_shift <= {read_shift[6:0], 1'b0};
        end
    end

    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            power_control <= REGISTER_RESET;
            output_buffer_disable_low <= REGISTER_RESET;
            output_buffer_disable_mid <= REGISTER_RESET;
            output_buffer_disable_high <= REGISTER_RESET;
            global_powerdown_mask <= REGISTER_RESET;
        end else if (write_commit) begin
            unique case (decode(frame[FRAME_BITS-2:8]))
                SEL_POWER: power_control <= frame[7:0] & POWER_CONTROL_WRITABLE;
                SEL_OB_LOW: output_buffer_disable_low <= frame[7:0];
                SEL_OB_MID: output_buffer_disable_mid <= frame[7:0];
                SEL_OB_HIGH: output_buffer_disable_high <= frame[7:0];
                SEL_MASK: global_powerdown_mask <= frame[7:0] & GLOBAL_MASK_WRITABLE;
                SEL_NONE: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // power-down decode
    // -----------------------------------------------------------------
    power_state_t next_power;
    pin_disable_t next_pins;
    logic global_sleep;

    assign global_sleep = power_control[POS_GLOBAL_SLEEP];

    always_comb begin
        next_power.clock_buffer_off = power_control[POS_CLOCK_BUFFER_OFF]
            | (global_sleep & ~global_powerdown_mask[POS_KEEP_CLOCK_BUFFER]);
        next_power.reference_amp_off = power_control[POS_REFERENCE_AMP_OFF]
            | (global_sleep & ~global_powerdown_mask[POS_KEEP_REFERENCE_AMP]);
        next_power.channel_a_off = power_control[POS_CHANNEL_A_OFF] | global_sleep;
        next_power.channel_b_off = power_control[POS_CHANNEL_B_OFF] | global_sleep;
        next_power.bandgap_off = global_sleep
            & global_powerdown_mask[POS_BANDGAP_SLEEP_SELECT];
    end

    always_comb begin
        next_pins.chan_a = {output_buffer_disable_high[1], output_buffer_disable_high[0],
            output_buffer_disable_mid[7], output_buffer_disable_high[3],
            output_buffer_disable_mid[5], output_buffer_disable_mid[4],
            output_buffer_disable_mid[3]};
        next_pins.chan_b = {output_buffer_disable_mid[0], output_buffer_disable_low[7],
            output_buffer_disable_low[6], output_buffer_disable_high[2],
            output_buffer_disable_low[4], output_buffer_disable_low[3],
            output_buffer_disable_low[2]};
    end

    // -----------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            POWER_DOWN <= '0;
            PIN_DISABLE <= '0;
            OUTPUT_BUFFER_DISABLE <= '0;
        end else begin
            POWER_DOWN <= next_power;
            PIN_DISABLE <= next_pins;
            OUTPUT_BUFFER_DISABLE <= {output_buffer_disable_high,
                output_buffer_disable_mid, output_buffer_disable_low};
        end
    end

endmodule

/* File: bench/power_down_output_buffer_ctrl_checker.sv */
// port assertions for the power-down and output buffer register bank
`timescale 1ns/1ps

module power_down_output_buffer_ctrl_checker
    import power_down_pkg::*;
(
    input wire logic REF_CLK, // system clock
    input wire logic RESET, // sync reset
    input wire logic SEN_N, // serial enable
    input wire logic SCLK, // serial clock
    input wire logic SDATA, // serial data in
    input wire logic SDOUT, // read data
    input wire logic SDOUT_OE, // read data drive
    input wire power_state_t POWER_DOWN, // block power-down
    input wire pin_disable_t PIN_DISABLE, // pin buffers off
    input wire logic [23:0] OUTPUT_BUFFER_DISABLE // raw field
);
    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    wire logic [23:0] o = OUTPUT_BUFFER_DISABLE;
    wire logic [13:0] pin_map = {o[17], o[16], o[15], o[19], o[13], o[12], o[11],
        o[8], o[7], o[6], o[18], o[4], o[3], o[2]};
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    property p_reset_zero;
        $fell(RESET) |-> POWER_DOWN == 5'h00 && o == 24'h000000
            && PIN_DISABLE == 14'h0000 && !SDOUT_OE;
    endproperty
    property p_pin_map;
        PIN_DISABLE == pin_map;
    endproperty
    property p_pins_follow_field;
        $changed(PIN_DISABLE) |-> $changed(OUTPUT_BUFFER_DISABLE);
    endproperty
    property p_bandgap_global;
        POWER_DOWN.bandgap_off |-> POWER_DOWN.channel_a_off && POWER_DOWN.channel_b_off;
    endproperty
    property p_field_latency;
        $changed(OUTPUT_BUFFER_DISABLE) && !$past(RESET) && !$past(RESET, 2)
            |-> $past(SEN_N, 2) == 1'b0;
    endproperty
    property p_power_latency;
        $changed(POWER_DOWN) && !$past(RESET) && !$past(RESET, 2) |-> $past(SEN_N, 2) == 1'b0;
    endproperty
    property p_one_register;
        $changed(POWER_DOWN) |-> $stable(OUTPUT_BUFFER_DISABLE);
    endproperty
    property p_readback_frame;
        SEN_N && $past(SEN_N) |-> !SDOUT_OE;
    endproperty

    a_reset_zero: assert property (p_reset_zero) else $error("not reset");
    a_pin_map: assert property (p_pin_map) else $error("pin map wrong");
    a_pins_follow_field: assert property (p_pins_follow_field) else $error("pin drift");
    a_bandgap_global: assert property (p_bandgap_global) else $error("bandgap alone");
    a_field_latency: assert property (p_field_latency) else $error("field late");
    a_power_latency: assert property (p_power_latency) else $error("power late");
    a_one_register: assert property (p_one_register) else $error("two registers moved");
    a_readback_frame: assert property (p_readback_frame) else $error("stray drive");

    c_read: cover property ($rose(SDOUT_OE));
    c_bandgap: cover property ($rose(POWER_DOWN.bandgap_off));
    c_field: cover property ($changed(OUTPUT_BUFFER_DISABLE));
endmodule

bind power_down_output_buffer_ctrl power_down_output_buffer_ctrl_checker
    power_down_output_buffer_ctrl_checker_i (.REF_CLK(REF_CLK), .RESET(RESET),
    .SEN_N(SEN_N), .SCLK(SCLK), .SDATA(SDATA), .SDOUT(SDOUT), .SDOUT_OE(SDOUT_OE),
    .POWER_DOWN(POWER_DOWN), .PIN_DISABLE(PIN_DISABLE),
    .OUTPUT_BUFFER_DISABLE(OUTPUT_BUFFER_DISABLE));

/* File: bench/power_down_output_buffer_ctrl_test.sv */
// self-checking bench for the power-down and output buffer register bank
`timescale 1ns/1ps

module power_down_output_buffer_ctrl_test
    import power_down_pkg::*;
;
    logic REF_CLK = 1'b0;
    logic RESET = 1'b1;
    logic SEN_N = 1'b1;
    logic SCLK = 1'b0;
    logic SDATA = 1'b0;
    logic SDOUT;
    logic SDOUT_OE;
    power_state_t POWER_DOWN;
    pin_disable_t PIN_DISABLE;
    logic [23:0] OUTPUT_BUFFER_DISABLE;
    int n_errors = 0;
    int n_checks = 0;
    logic [7:0] rd;
    logic [23:0] exp;
    logic [14:0] addr_tab [5] = '{ADDR_POWER_CONTROL, ADDR_OUTPUT_BUFFER_DISABLE_LOW,
        ADDR_OUTPUT_BUFFER_DISABLE_MID, ADDR_OUTPUT_BUFFER_DISABLE_HIGH,
        ADDR_GLOBAL_POWERDOWN_MASK};
    // mask, control, expected power-down levels
    logic [7:0] pd_tab [9][3] = '{'{8'h00, 8'h20, 8'h10}, '{8'h00, 8'h10, 8'h08},
        '{8'h00, 8'h04, 8'h04}, '{8'h00, 8'h02, 8'h02}, '{8'h00, 8'h01, 8'h1e},
        '{8'h08, 8'h01, 8'h0e}, '{8'h04, 8'h01, 8'h16}, '{8'h02, 8'h01, 8'h1f},
        '{8'h0e, 8'h21, 8'h17}};
    // low, mid, high disable bytes per interface mode
    // recommended bytes per mode
    logic [7:0] ob_tab [4][3] = '{'{8'h23, 8'h46, 8'hf0}, '{8'h7f, 8'hee, 8'hfc},
        '{8'hff, 8'hee, 8'hfd}, '{8'hff, 8'hef, 8'hfd}};

    always #50 REF_CLK = ~REF_CLK;

    power_down_output_buffer_ctrl power_down_output_buffer_ctrl_i (.REF_CLK(REF_CLK),
        .RESET(RESET), .SEN_N(SEN_N), .SCLK(SCLK), .SDATA(SDATA), .SDOUT(SDOUT),
        .SDOUT_OE(SDOUT_OE), .POWER_DOWN(POWER_DOWN), .PIN_DISABLE(PIN_DISABLE),
        .OUTPUT_BUFFER_DISABLE(OUTPUT_BUFFER_DISABLE));

    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task automatic results;
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] e);
        n_checks++;
        if (seen !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
        end
    endtask

    // one frame, cut short after nbits; three REF_CLK cycles per SCLK phase
    task automatic frame(input logic rw, input logic [14:0] a, input logic [7:0] d,
                         input int nbits, output logic [7:0] q);
        logic [23:0] f;
        f = {rw, a, d};
        q = 8'h00;
        @(posedge REF_CLK);
        SEN_N <= 1'b0;
        for (int i = 23; i >= 24 - nbits; i--) begin
            SDATA <= f[i];
            repeat (3) @(posedge REF_CLK);
            if (i < 8) q[i] = SDOUT;
            SCLK <= 1'b1;
            repeat (3) @(posedge REF_CLK);
            SCLK <= 1'b0;
        end
        repeat (3) @(posedge REF_CLK);
        SEN_N <= 1'b1;
        repeat (2) @(posedge REF_CLK);
    endtask

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] q;
        frame(1'b0, a, d, 24, q);
    endtask

    task automatic rchk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] q;
        frame(1'b1, a, 8'h00, 24, q);
        check($sformatf("read %h", a), 24'(q), 24'(e));
    endtask

    function automatic logic [13:0] pins(input logic [23:0] o);
        return {o[17], o[16], o[15], o[19], o[13], o[12], o[11],
                o[8], o[7], o[6], o[18], o[4], o[3], o[2]};
    endfunction

    // -----------------------------------------------------------------
    // sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        foreach (addr_tab[k]) rchk(addr_tab[k], 8'h00);
        check("power", 24'(POWER_DOWN), 24'h0);
        wr(ADDR_POWER_CONTROL, 8'hff);
        rchk(ADDR_POWER_CONTROL, 8'h37);
        check("power", 24'(POWER_DOWN), 24'h1e);
        wr(ADDR_GLOBAL_POWERDOWN_MASK, 8'hff);
        rchk(ADDR_GLOBAL_POWERDOWN_MASK, 8'h0e);
        check("power", 24'(POWER_DOWN), 24'h1f);
        foreach (pd_tab[k]) begin
            wr(ADDR_GLOBAL_POWERDOWN_MASK, pd_tab[k][0]);
            wr(ADDR_POWER_CONTROL, pd_tab[k][1]);
            exp = 24'(pd_tab[k][2]);
            check("power", 24'(POWER_DOWN), exp);
        end
        wr(15'h0009, 8'hff);
        rchk(15'h0009, 8'h00);
        wr(15'h4008, 8'h00);
        rchk(ADDR_POWER_CONTROL, 8'h21);
        foreach (ob_tab[k]) begin
            wr(ADDR_OUTPUT_BUFFER_DISABLE_LOW, ob_tab[k][0]);
            wr(ADDR_OUTPUT_BUFFER_DISABLE_MID, ob_tab[k][1]);
            wr(ADDR_OUTPUT_BUFFER_DISABLE_HIGH, ob_tab[k][2]);
            exp = {ob_tab[k][2], ob_tab[k][1], ob_tab[k][0]};
            check("field", OUTPUT_BUFFER_DISABLE, exp);
            check("pins", 24'(PIN_DISABLE), 24'(pins(exp)));
            rchk(ADDR_OUTPUT_BUFFER_DISABLE_LOW, ob_tab[k][0]);
            rchk(ADDR_OUTPUT_BUFFER_DISABLE_MID, ob_tab[k][1]);
            rchk(ADDR_OUTPUT_BUFFER_DISABLE_HIGH, ob_tab[k][2]);
        end
        check("power", 24'(POWER_DOWN), 24'h17);
        frame(1'b0, ADDR_OUTPUT_BUFFER_DISABLE_LOW, 8'h00, 20, rd);
        check("field", OUTPUT_BUFFER_DISABLE, exp);
        @(posedge REF_CLK);
        RESET <= 1'b1;
        repeat (4) @(posedge REF_CLK);
        RESET <= 1'b0;
        @(posedge REF_CLK);
        check("field", OUTPUT_BUFFER_DISABLE, 24'h0);
        check("power", 24'(POWER_DOWN), 24'h0);
        check("pins", 24'(PIN_DISABLE), 24'h0);
        rchk(ADDR_POWER_CONTROL, 8'h00);
        results();
    end

    initial begin
        repeat (100000) @(posedge REF_CLK);
        n_errors++;
        results();
    end
endmodule
